// ===== hdl/sadc_device.sv
// Converter end of the link: sample, successive approximation, serial out
//
// Function
// RL1: Frame select fall starts conversion and transfer
// RL2: Frame select fall starts driving the output
// RL3: Frame select fall captures the sample, hold
// RL4: Return to track on 13th rising edge
// RL5: Host waits 350 ns from 13th rise
// RL6: Release output after 16th fall or select rise
// RL7: Host waits quiet interval before next start
// RL8: Edges counted from the frame select fall
// RL9: Only host serial clock edges advance conversion
// RL10: Successive approximation trial code becomes the result
// RL11: Start spacing is acquisition plus conversion
// RL12: Every output code is reachable
// RL13: Sixteen clocks: three zeros, eight bits, four zeros
// RL14: Rise between falls two and ten shuts down
// RL15: Rise after tenth fall aborts, stays normal
// RL16: Host keeps 50 ns quiet before next start
// RL17: Frame select high ignores clock, output released
`timescale 1ns/1ps
`default_nettype none
module sadc_device #(
  parameter int unsigned RES_W = sadc_pkg::DATA_BITS
) (
  sadc_link_if.dev         link,
  input  wire logic        rst_n,
  input  wire logic [RES_W-1:0] analogIn,
  output logic             shutdown,
  output logic             tracking,
  output logic [RES_W-1:0] lastResult,
  output logic             resultDone
);

  // ----------------------------------------------------------------
  // State of the converter
  // ----------------------------------------------------------------
  logic [RES_W-1:0]        heldSample_r;   // Charge on the sampling capacitor
  logic [sadc_pkg::CNT_W-1:0] fallCnt_r;   // Falling edges since select fall
  logic [sadc_pkg::CNT_W-1:0] riseCnt_r;   // Rising edges since select fall
  logic [RES_W-1:0]        trial_r;        // Successive approximation word
  logic                    sdo_r;          // Bit on the data wire
  logic                    released_r;     // Output let go after 16th fall
  logic                    backToTrack_r;  // Track regained inside the frame
  logic                    shutdown_r;     // Power mode picked at select rise
  logic [RES_W-1:0]        lastResult_r;   // Word of the last whole frame
  logic                    resultDone_r;   // Set once any frame has run to its end, kept until reset
  logic [RES_W-1:0]        candidate;
  logic [sadc_pkg::CNT_W-1:0] bitIdx;
  logic                    sarStep;
  logic                    dataSlot;

  // ----------------------------------------------------------------
  // Sample and hold
  // ----------------------------------------------------------------
  // The analog level is frozen by the select fall itself; the
  // capacitor is the holding element, no synchroniser applies here
  // Trade-off: the held word is a plain copy, no settling is modelled
  always_ff @(negedge link.csN) begin
    heldSample_r <= analogIn; // RL3
  end

  // ----------------------------------------------------------------
  // Edge counters
  // ----------------------------------------------------------------
  // Select high clears the counters at once, so the very first fall
  // after the select fall counts as edge one
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      fallCnt_r <= '0; // RL17
    end else if (fallCnt_r != '1) begin
      fallCnt_r <= fallCnt_r + 1'b1; // RL8
    end
  end

  // Rising edges, counted the same way; saturate so long idle-low
  // clocking cannot wrap back into the frame
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      riseCnt_r <= '0;
    end else if (riseCnt_r != '1) begin
      riseCnt_r <= riseCnt_r + 1'b1; // RL8
    end
  end

  // ----------------------------------------------------------------
  // Track and hold
  // ----------------------------------------------------------------
  // Hold runs from the select fall until the 13th rising edge
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      backToTrack_r <= 1'b0;
    end else if (riseCnt_r == sadc_pkg::TRACK_AT) begin
      backToTrack_r <= 1'b1; // RL4
    end
  end

  // Select high means tracking; a fall moves to hold at once
  assign tracking = link.csN | backToTrack_r; // RL3

  // ----------------------------------------------------------------
  // Successive approximation
  // ----------------------------------------------------------------
  // Falls two to nine each decide one bit, MSB first, and only the
  // host's own clock edges step it; no internal clock exists
  assign sarStep   = (fallCnt_r >= sadc_pkg::SAR_LO_CNT - 5'h01) &&
                     (fallCnt_r <= sadc_pkg::SAR_HI_CNT - 5'h01);
  assign bitIdx    = sadc_pkg::SAR_HI_CNT - 5'h01 - fallCnt_r;
  assign candidate = trial_r | (RES_W'(1) << bitIdx[2:0]);

  // Keep a trial bit only while the trial stays at or below the
  // held charge; full-scale and zero both stay reachable
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      trial_r <= sadc_pkg::RESULT_RST;
    end else if (sarStep) begin
      if (candidate <= heldSample_r) begin // RL10 RL12
        trial_r <= candidate; // RL9
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Falls three to ten present the result, MSB first; all other
  // slots of the frame are zero
  assign dataSlot = (fallCnt_r >= sadc_pkg::DOUT_LO_CNT - 5'h01) &&
                    (fallCnt_r <= sadc_pkg::DOUT_HI_CNT - 5'h01);

  // Each bit is decided one fall before it is shown, which keeps the
  // approximation exactly one step ahead of the shifter
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      sdo_r <= 1'b0;
    end else if (dataSlot) begin
      sdo_r <= trial_r[3'(sadc_pkg::DOUT_HI_CNT - 5'h01 - fallCnt_r)]; // RL13
    end else begin
      sdo_r <= 1'b0; // RL13
    end
  end

  // Release flag set by the 16th fall, cleared by select high; a host
  // that idles select low after the frame keeps the wire released
  // until select has been high once, the only legal restart
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      released_r <= 1'b0;
    end else if (fallCnt_r == sadc_pkg::FALLS_END - 5'h01) begin
      released_r <= 1'b1; // RL6
    end
  end

  // Driving needs no clock edge: it starts with the select fall and
  // ends at select rise or after the 16th fall, whichever is first
  assign link.sdoOeN = link.csN | released_r; // RL2 RL6 RL17 RL14 RL15
  assign link.sdoOut = sdo_r; // RL1

  // ----------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------
  // Read at select rise; counts below two leave the mode alone so a
  // glitch on the select line cannot shut the converter down
  // A frame cut at exactly ten falls counts as kept low long enough,
  // so the converter stays in normal mode then
  always_ff @(posedge link.csN or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_r <= 1'b0;
    end else if (fallCnt_r >= sadc_pkg::SHDN_LO_CNT &&
                 fallCnt_r <  sadc_pkg::SHDN_HI_CNT) begin
      shutdown_r <= 1'b1; // RL14
    end else if (fallCnt_r >= sadc_pkg::SHDN_HI_CNT) begin
      shutdown_r <= 1'b0; // RL15
    end
  end

  // A select fall wakes the converter for the new conversion
  assign shutdown = shutdown_r & link.csN; // RL14

  // ----------------------------------------------------------------
  // Result of the last whole frame
  // ----------------------------------------------------------------
  // Only a frame that reaches its 16th fall counts; an aborted one
  // leaves the previous word in place
  always_ff @(negedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      lastResult_r <= sadc_pkg::RESULT_RST;
      resultDone_r <= 1'b0;
    end else if (!link.csN && fallCnt_r == sadc_pkg::FALLS_END - 5'h01) begin
      lastResult_r <= trial_r; // RL10
      resultDone_r <= 1'b1;
    end
  end

  assign lastResult = lastResult_r;
  assign resultDone = resultDone_r;

  // ----------------------------------------------------------------
  // Obligations of the host
  // ----------------------------------------------------------------
  // The acquire_interval and quiet time after a frame are kept by the
  // host; an early select fall here gives a poorly settled sample,
  // and the sequencing above still restarts cleanly at edge one
  // RL5 RL7 RL11 RL16
  // Limitation: the converter cannot measure that gap, having no
  // clock of its own; a host that starts early still gets a
  // full-length frame, with a word from a partly charged sample

endmodule
`default_nettype wire

// ===== hdl/sadc_fifo.sv
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             doWr;
  logic             doRd;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  assign inReady  = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  // Storage; no reset so it maps onto plain memory
  always_ff @(posedge core_clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (doWr) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
    end
  end

  // Fill level
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (doWr && !doRd) begin
      count_r <= count_r + 1'b1;
    end else if (doRd && !doWr) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/sadc_host.sv
// Host end of the link: clock divider, frame sequencing, result FIFO
`timescale 1ns/1ps
`default_nettype none
module sadc_host #(
  parameter int unsigned SCLK_HALF  = sadc_pkg::SCLK_HALF_DEF,
  parameter int unsigned FIFO_DEPTH = 32,
  parameter int unsigned RES_W      = sadc_pkg::DATA_BITS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  sadc_link_if.host        link,
  input  wire logic        startValid,
  output logic             startReady,
  input  wire logic [4:0]  startFalls,
  output logic             rdValid,
  input  wire logic        rdReady,
  output logic [RES_W-1:0] rdData,
  output logic             busy
);
  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
  localparam logic [7:0] GAP_M1  = 8'(sadc_pkg::ACQ_CYC - 1);

  sadc_pkg::sadc_hstate_t state_r;
  logic [7:0]       tick_r;
  logic [4:0]       fallCnt_r;
  logic [4:0]       target_r;
  logic [15:0]      shift_r;
  logic             sclk_r;
  logic             csN_r;
  logic             sdoMeta_r;
  logic             sdoSync_r;
  logic             fifoInReady;
  logic             fifoInValid;
  logic             tickDone;

  assign tickDone = (tick_r == '0);

  // ----------------------------------------------------------------
  // Data wire synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdoMeta_r <= 1'b0;
      sdoSync_r <= 1'b0;
    end else begin
      sdoMeta_r <= link.sdoLine;
      sdoSync_r <= sdoMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and clock divider
  // ----------------------------------------------------------------
  // Start only with room in the FIFO, so a slow reader stalls the
  // converter instead of losing words
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= sadc_pkg::HS_IDLE;
      tick_r    <= '0;
      fallCnt_r <= '0;
      target_r  <= sadc_pkg::FALLS_END;
      shift_r   <= sadc_pkg::SHIFT_RST;
      sclk_r    <= 1'b1;
      csN_r     <= 1'b1;
    end else begin
      case (state_r)
        sadc_pkg::HS_IDLE: begin
          if (startValid && fifoInReady) begin
            csN_r     <= 1'b0; // RL1
            tick_r    <= HALF_M1;
            fallCnt_r <= '0;
            target_r  <= (startFalls == '0 || startFalls > sadc_pkg::FALLS_END) ?
                         sadc_pkg::FALLS_END : startFalls;
            state_r   <= sadc_pkg::HS_SETUP;
          end
        end
        sadc_pkg::HS_SETUP: begin
          // Select falls with the clock high; first fall is edge one
          if (tickDone) begin
            sclk_r  <= 1'b0;
            tick_r  <= HALF_M1;
            fallCnt_r <= 5'h01; // RL8
            shift_r <= {shift_r[14:0], sdoSync_r}; // RL13
            state_r <= sadc_pkg::HS_RUN;
          end else begin
            tick_r <= tick_r - 1'b1;
          end
        end
        sadc_pkg::HS_RUN: begin
          if (!tickDone) begin
            tick_r <= tick_r - 1'b1;
          end else if (sclk_r) begin
            sclk_r    <= 1'b0;
            tick_r    <= HALF_M1;
            fallCnt_r <= fallCnt_r + 1'b1; // RL8
            shift_r   <= {shift_r[14:0], sdoSync_r}; // RL13
          end else if (fallCnt_r == target_r) begin
            tick_r  <= HALF_M1;
            state_r <= sadc_pkg::HS_ENDW;
          end else begin
            sclk_r <= 1'b1;
            tick_r <= HALF_M1;
          end
        end
        sadc_pkg::HS_ENDW: begin
          // Raise select with the clock low, then keep the gap
          csN_r   <= 1'b1; // RL14 RL15
          tick_r  <= GAP_M1;
          state_r <= sadc_pkg::HS_GAP;
        end
        sadc_pkg::HS_GAP: begin
          // Gap covers both acquire_interval and the quiet time
          if (tickDone) begin
            sclk_r  <= 1'b1;
            state_r <= (target_r == sadc_pkg::FALLS_END) ?
                       sadc_pkg::HS_PUSH : sadc_pkg::HS_IDLE; // RL5 RL7 RL11 RL16
          end else begin
            tick_r <= tick_r - 1'b1;
          end
        end
        sadc_pkg::HS_PUSH: begin
          if (fifoInReady) begin
            state_r <= sadc_pkg::HS_IDLE;
          end
        end
        default: begin
          state_r <= sadc_pkg::HS_IDLE;
        end
      endcase
    end
  end

  assign link.sclk   = sclk_r;
  assign link.csN    = csN_r;
  assign startReady  = (state_r == sadc_pkg::HS_IDLE) & fifoInReady;
  assign busy        = (state_r != sadc_pkg::HS_IDLE);
  assign fifoInValid = (state_r == sadc_pkg::HS_PUSH);

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  // Bits 3..10 of the frame sit at shift positions 12..5
  sadc_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (shift_r[12:5]),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );
endmodule
`default_nettype wire

// ===== hdl/sadc_link_if.sv
// Four-wire link between the host and the converter
`timescale 1ns/1ps
`default_nettype none
interface sadc_link_if;
  logic sclk;        // Serial clock, made by the host
  logic csN;         // Frame select, active low
  logic sdoOut;      // serial_result_out level from the converter
  logic sdoOeN;      // Converter output enable, low while driving
  logic sdoLine;     // Resolved level of the data wire

  // Released wire reads low, as with a weak pull-down
  assign sdoLine = sdoOeN ? 1'b0 : sdoOut;

  modport dev (
    input  sclk,
    input  csN,
    output sdoOut,
    output sdoOeN
  );

  modport host (
    output sclk,
    output csN,
    input  sdoLine
  );
endinterface
`default_nettype wire

// ===== hdl/sadc_pkg.sv
// Shared constants and types of the serial converter frame, both ends
`default_nettype none
package sadc_pkg;

  // ----------------------------------------------------------------
  // Frame layout in serial clock edges
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_FALLS  = 16;  // Falling edges of one whole frame
  localparam int unsigned TRACK_RISE   = 13;  // Rising edge that returns to track
  localparam int unsigned LEAD_ZEROS   = 3;   // Zeros ahead of the result
  localparam int unsigned DATA_BITS    = 8;   // Result width
  localparam int unsigned TRAIL_ZEROS  = 4;   // Zeros after the result
  localparam int unsigned SHDN_FIRST   = 2;   // First fall count that arms shutdown
  localparam int unsigned SHDN_LAST    = 10;  // Fall count from which normal mode stays
  localparam int unsigned SAR_FIRST    = 2;   // Falling edge that decides the MSB
  localparam int unsigned CNT_W        = 5;   // Width of the edge counters

  // Edge counts at counter width
  localparam logic [4:0] FALLS_END     = 5'h10;
  localparam logic [4:0] TRACK_AT      = 5'h0C; // Count before the 13th rise
  localparam logic [4:0] SHDN_LO_CNT   = 5'h02;
  localparam logic [4:0] SHDN_HI_CNT   = 5'h0A;
  localparam logic [4:0] SAR_LO_CNT    = 5'h02;
  localparam logic [4:0] SAR_HI_CNT    = 5'h09;
  localparam logic [4:0] DOUT_LO_CNT   = 5'h03;
  localparam logic [4:0] DOUT_HI_CNT   = 5'h0A;

  // ----------------------------------------------------------------
  // Timing of the host side
  // ----------------------------------------------------------------
  localparam int unsigned CORE_PERIOD_PS   = 5000;   // 200 MHz core clock
  localparam int unsigned ACQ_NS           = 350;    // acquire_interval, least
  localparam int unsigned QUIET_NS         = 50;     // Quiet interval, least
  localparam int unsigned ACQ_CYC   = (ACQ_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int unsigned QUIET_CYC = (QUIET_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam int unsigned SCLK_HALF_DEF    = 5;      // Core cycles per half serial period
  localparam int unsigned GAP_W            = 8;      // Width of the gap counter

  // Reset values
  localparam logic [7:0]  RESULT_RST  = 8'h00;
  localparam logic [15:0] SHIFT_RST   = 16'h0000;

  // Host sequencing states
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SETUP,
    HS_RUN,
    HS_ENDW,
    HS_GAP,
    HS_PUSH
  } sadc_hstate_t;

endpackage
`default_nettype wire

// ===== test/sadc_link_properties.sv
// Timing properties of the four-wire link between host and converter
`timescale 1ns/1ps
`default_nettype none
module sadc_link_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdoOut,
  input wire logic sdoOeN,
  input wire logic sdoLine
);
  localparam int ACQ_MIN   = 70;  // 350 ns at the core rate
  localparam int QUIET_MIN = 10;  // 50 ns at the core rate

  logic       sclkQ_r;
  logic       oeQ_r;
  logic [4:0] fallCnt_r;
  logic [4:0] riseCnt_r;
  logic [7:0] sinceTrack_r;
  logic [7:0] sinceRel_r;
  logic       sclkFall;
  logic       sclkRise;
  logic [4:0] fallsNow;

  // ----------------------------------------------------------------
  // Edge bookkeeping
  // ----------------------------------------------------------------
  // Core-rate sampling is exact since the host launches sclk from core flops
  assign sclkFall = sclkQ_r & ~sclk;
  assign sclkRise = ~sclkQ_r & sclk;
  assign fallsNow = fallCnt_r + {4'h0, sclkFall};

  // Previous levels of the clock and the output enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ_r <= 1'b1;
      oeQ_r   <= 1'b1;
    end else begin
      sclkQ_r <= sclk;
      oeQ_r   <= sdoOeN;
    end
  end

  // Edges counted from the select fall; cleared while deselected
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fallCnt_r <= 5'h00;
      riseCnt_r <= 5'h00;
    end else if (csN) begin
      fallCnt_r <= 5'h00;
      riseCnt_r <= 5'h00;
    end else begin
      fallCnt_r <= fallsNow;
      riseCnt_r <= riseCnt_r + {4'h0, sclkRise};
    end
  end

  // Saturating cycle counts since track resumed and since release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sinceTrack_r <= 8'hFF;
      sinceRel_r   <= 8'hFF;
    end else begin
      sinceTrack_r <= (!csN && sclkRise && riseCnt_r == 5'h0C) ? 8'h00
                    : sinceTrack_r + {7'h00, sinceTrack_r != 8'hFF};
      sinceRel_r   <= (!oeQ_r && sdoOeN) ? 8'h00
                    : sinceRel_r + {7'h00, sinceRel_r != 8'hFF};
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence frameOpen;
    $fell(csN) ##0 sclk;
  endsequence
  sequence setupHeld;
    (sclk && !csN)[*4] ##1 (!sclk && !csN);
  endsequence

  release_idle_a: assert property (csN |-> sdoOeN)
    else $error("output driven while deselected");
  drive_in_frame_a: assert property (!csN && fallsNow < 5'h10 |-> !sdoOeN)
    else $error("output not driven inside frame");
  release_last_a: assert property (!csN && fallsNow >= 5'h10 |-> sdoOeN)
    else $error("output still driven after last fall");
  lead_zeros_a: assert property (!csN && fallsNow < 5'h03 |-> !sdoLine)
    else $error("leading bit not zero");
  trail_zeros_a: assert property (!csN && fallsNow > 5'h0A && fallsNow < 5'h10
      |-> !sdoLine)
    else $error("trailing bit not zero");
  data_on_fall_a: assert property (!csN && !$past(csN) && !sdoOeN && $changed(sdoOut)
      |-> sclkFall)
    else $error("data moved without a clock fall");
  acq_gap_a: assert property ($fell(csN) |-> sinceTrack_r >= ACQ_MIN)
    else $error("acquire interval too short");
  quiet_gap_a: assert property ($fell(csN) |-> sinceRel_r >= QUIET_MIN)
    else $error("quiet interval too short");
  setup_first_a: assert property (frameOpen |=> setupHeld)
    else $error("first clock fall misplaced");
endmodule
`default_nettype wire

// ===== test/serial_adc_conversion_frame_test.sv
// Self-checking bench: host and converter joined over the link
`timescale 1ns/1ps
`default_nettype none
module serial_adc_conversion_frame_test;
  logic       core_clk;
  logic       rst_n;
  logic       startValid;
  logic       startReady;
  logic [4:0] startFalls;
  logic       rdValid;
  logic       rdReady;
  logic [7:0] rdData;
  logic       busy;
  logic [7:0] analogIn;
  logic       shutdown;
  logic       tracking;
  logic [7:0] lastResult;
  logic       resultDone;
  logic [7:0] expQ[$];
  logic       shutExp;
  int         err_count;
  int         num_checks;
  int         n;
  logic [7:0] codeTab[4] = '{8'h00, 8'hFF, 8'h80, 8'h7F};
  logic [4:0] fallTab[9] = '{5'h05, 5'h01, 5'h0C, 5'h01, 5'h02, 5'h09, 5'h0A, 5'h0F, 5'h10};

  sadc_link_if link ();
  sadc_host sadc_host_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link),
    .startValid(startValid), .startReady(startReady), .startFalls(startFalls),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .busy(busy));
  sadc_device sadc_device_inst (.link(link), .rst_n(rst_n), .analogIn(analogIn),
    .shutdown(shutdown), .tracking(tracking), .lastResult(lastResult),
    .resultDone(resultDone));
  sadc_link_properties sadc_link_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
    .sclk(link.sclk), .csN(link.csN), .sdoOut(link.sdoOut), .sdoOeN(link.sdoOeN),
    .sdoLine(link.sdoLine));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Compare and report tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One frame of the given length; a full frame notes its expected word
  task automatic run_frame(input logic [7:0] val, input logic [4:0] falls);
    int k;
    k = 0;
    @(negedge core_clk);
    analogIn   = val;
    startFalls = falls;
    startValid = 1'b1;
    if (falls == 5'h10) expQ.push_back(val);
    // Ready is settled at the falling edge; the next rising edge takes it
    while (startReady !== 1'b1 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    @(negedge core_clk);
    startValid = 1'b0;
    while (link.csN !== 1'b0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    if (falls == 5'h10) begin
      repeat (60) @(negedge core_clk);
      chk_bit(tracking, 1'b0);
      repeat (80) @(negedge core_clk);
      chk_bit(tracking, 1'b1);
      // Between the 16th fall and the select rise the wire is let go
      repeat (17) @(negedge core_clk);
      chk_bit(link.csN, 1'b0);
      chk_bit(link.sdoOeN, 1'b1);
    end
    while (busy !== 1'b0 && k < 2000) begin
      @(negedge core_clk);
      k++;
    end
    // A hung handshake shows up as a mismatch rather than a silent stall
    if (k >= 2000) chk_bit(1'b0, 1'b1);
    chk_bit(link.sdoOeN, 1'b1);
  endtask

  // Result watcher: each word read out takes the oldest note
  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && rdValid === 1'b1 && rdReady === 1'b1) begin
      if (expQ.size() == 0) chk_bit(1'b1, 1'b0);
      else chk_byte(rdData, expQ.pop_front());
    end
  end

  // Watchdog sized well above the roughly 11500 cycles of the run
  initial begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    startValid = 1'b0;
    startFalls = 5'h10;
    rdReady    = 1'b1;
    analogIn   = 8'h00;
    shutExp    = 1'b0;
    err_count  = 0;
    num_checks = 0;
    n          = 0;
    void'($urandom(23));
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    chk_bit(resultDone, 1'b0);
    for (int i = 0; i < 10; i++) begin
      run_frame(i < 4 ? codeTab[i] : 8'($urandom), 5'h10);
      chk_byte(lastResult, analogIn);
    end
    chk_bit(resultDone, 1'b1);
    $display("test full_frames done");
    // Cut frames at both sides of the shutdown window, then a full one
    foreach (fallTab[i]) begin
      run_frame(8'($urandom), fallTab[i]);
      if (fallTab[i] >= 5'h02 && fallTab[i] <= 5'h09) shutExp = 1'b1;
      else if (fallTab[i] >= 5'h0A) shutExp = 1'b0;
      chk_bit(shutdown, shutExp);
    end
    $display("test truncation done");
    // Fill the buffer with reads stalled, then drain with random stalls
    repeat (4) @(negedge core_clk);
    rdReady = 1'b0;
    repeat (32) run_frame(8'($urandom), 5'h10);
    @(negedge core_clk);
    chk_bit(startReady, 1'b0);
    while (expQ.size() != 0 && n < 5000) begin
      @(negedge core_clk);
      rdReady = 1'($urandom);
      n++;
    end
    rdReady = 1'b1;
    repeat (3) @(negedge core_clk);
    // Words still noted but never read out count against the run
    chk_bit(expQ.size() == 0, 1'b1);
    chk_bit(rdValid, 1'b0);
    chk_bit(startReady, 1'b1);
    $display("test fifo_full done");
    final_report();
  end
endmodule
`default_nettype wire
